// File: core/upx_exchange.sv
// User program exchange bank: selection tables, input/init/output arrays
`default_nettype none
// How it works
// - Sixteen read-only zero descriptors, count 10h
// - Descriptor bits 31..16 hold object index
// - Descriptor bits 15..8 hold subindex
// - Descriptor bits 7..0 hold bit length
// - Copy mapped objects in before, out after
// - Thirty-two read/write input words, count 20h
// - Input words used only by user program
// - Init parameter array, storable in non-volatile memory
// - Thirty-two read/write output words for master
// - Writing read-only entry aborts with 1001h
// - Nonexistent object aborts with 1000h
// - Too many in/out variables flags 4000000h
module upx_exchange (
  input wire logic mclk,
  input wire logic rst,
  // Fieldbus object access
  input wire logic od_req,
  input wire logic od_write,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic [31:0] od_wdata,
  output logic od_done,
  output logic [31:0] od_rdata,
  output logic [31:0] od_abort,
  // User program side
  input wire logic prog_start,
  input wire logic [5:0] prog_inout_decl,
  output logic prog_running,
  output logic prog_cycle_done,
  output logic [31:0] prog_map_error,
  input wire logic prog_we,
  input wire logic [4:0] prog_addr,
  input wire logic [31:0] prog_wdata,
  output logic [31:0] prog_input_rdata,
  output logic [31:0] prog_init_rdata,
  output logic [31:0] prog_output_rdata,
  output logic [4:0] xfer_slot,
  output logic [31:0] xfer_desc,
  output logic xfer_in_valid,
  output logic xfer_out_valid,
  // Non-volatile store of the init parameters
  input wire logic nv_we,
  input wire logic [4:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  output logic [31:0] nv_rdata
);
  import upx_pkg::*;

  // ------------------------------------------------------------
  // Object decode
  // ------------------------------------------------------------
  // Word arrays accept subindex 1..20h; returns 1 when in range
  function automatic logic word_sub_ok(input logic [7:0] sub);
    return (sub != 8'h00) && (sub <= UPX_WORD_COUNT);
  endfunction : word_sub_ok

  // Selection tables accept subindex 1..10h
  function automatic logic map_sub_ok(input logic [7:0] sub);
    return (sub != 8'h00) && (sub <= UPX_MAP_COUNT);
  endfunction : map_sub_ok

  logic is_map; // Either selection table addressed
  logic is_in; // Input array addressed
  logic is_init; // Init parameter array addressed
  logic is_out; // Output array addressed
  logic [4:0] word_sel; // Subindex minus one
  logic [31:0] in_rd; // Input array read to master
  logic [31:0] init_rd; // Init array read to master
  logic [31:0] out_rd; // Output array read to master
  logic [31:0] init_nv_rd; // Init array read to store
  logic [31:0] desc_mem [UPX_MAP_N]; // Descriptor table
  logic fb_we_in; // Accepted master write, input array
  logic fb_we_init; // Accepted master write, init array
  logic fb_we_out; // Accepted master write, output array

  assign is_map = (od_index == UPX_IDX_INOUT_MAP) || (od_index == UPX_IDX_OUT_MAP);
  assign is_in = od_index == UPX_IDX_INPUT;
  assign is_init = od_index == UPX_IDX_INIT;
  assign is_out = od_index == UPX_IDX_OUTPUT;
  assign word_sel = 5'(od_subindex - 8'h01);

  // Descriptors are read-only and preset to zero; nothing writes them here
  genvar gd;
  generate
    for (gd = 0; gd < UPX_MAP_N; gd++) begin : g_desc
      assign desc_mem[gd] = UPX_MAP_RESET;
    end
  endgenerate

  // ------------------------------------------------------------
  // Write acceptance
  // ------------------------------------------------------------
  // Only data words of the three arrays are writable by the master
  assign fb_we_in = od_req && od_write && is_in && word_sub_ok(od_subindex);
  assign fb_we_init = od_req && od_write && is_init && word_sub_ok(od_subindex);
  assign fb_we_out = od_req && od_write && is_out && word_sub_ok(od_subindex);

  // ------------------------------------------------------------
  // Arrays
  // ------------------------------------------------------------
  // Input words: master writes and reads them back, the user program reads them; no
  // other logic here taps this array, and it has no store path
  upx_word_bank u_input (
    .mclk(mclk),
    .rst(rst),
    .reset_value(UPX_INPUT_RESET),
    .a_we(fb_we_in),
    .a_addr(word_sel),
    .a_wdata(od_wdata),
    .a_rdata(in_rd),
    .b_we(1'b0),
    .b_addr(prog_addr),
    .b_wdata(prog_wdata),
    .b_rdata(prog_input_rdata)
  );

  // Init parameters: second port belongs to the non-volatile store
  upx_word_bank u_init (
    .mclk(mclk),
    .rst(rst),
    .reset_value(UPX_INIT_RESET),
    .a_we(fb_we_init),
    .a_addr(word_sel),
    .a_wdata(od_wdata),
    .a_rdata(init_rd),
    .b_we(nv_we),
    .b_addr(nv_addr),
    .b_wdata(nv_wdata),
    .b_rdata(init_nv_rd)
  );

  assign nv_rdata = init_nv_rd;
  assign prog_init_rdata = init_rd;

  // Output words: program writes results, master may also write
  upx_word_bank u_output (
    .mclk(mclk),
    .rst(rst),
    .reset_value(UPX_OUTPUT_RESET),
    .a_we(fb_we_out),
    .a_addr(word_sel),
    .a_wdata(od_wdata),
    .a_rdata(out_rd),
    .b_we(prog_we),
    .b_addr(prog_addr),
    .b_wdata(prog_wdata),
    .b_rdata(prog_output_rdata)
  );

  // ------------------------------------------------------------
  // Object access answer
  // ------------------------------------------------------------
  // One-cycle answer; read data and abort code held until next request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      od_done <= 1'b0;
      od_rdata <= 32'h0000_0000;
      od_abort <= UPX_ERR_NONE;
    end else begin
      od_done <= od_req;
      if (od_req) begin
        od_rdata <= 32'h0000_0000;
        od_abort <= UPX_ERR_NONE;
        if (is_map && od_subindex == 8'h00) begin
          if (od_write) begin
            od_abort <= UPX_ERR_READ_ONLY;
          end else begin
            od_rdata <= {24'h00_0000, UPX_MAP_COUNT};
          end
        end else if (is_map && map_sub_ok(od_subindex)) begin
          if (od_write) begin
            od_abort <= UPX_ERR_READ_ONLY;
          end else begin
            od_rdata <= desc_mem[4'(od_subindex - 8'h01)];
          end
        end else if ((is_in || is_init || is_out) && od_subindex == 8'h00) begin
          if (od_write) begin
            od_abort <= UPX_ERR_READ_ONLY;
          end else begin
            od_rdata <= {24'h00_0000, UPX_WORD_COUNT};
          end
        end else if ((is_in || is_init || is_out) && word_sub_ok(od_subindex)) begin
          // Writes already applied by the banks; reads return current word
          if (!od_write) begin
            od_rdata <= is_in ? in_rd : (is_init ? init_rd : out_rd);
          end
        end else begin
          od_abort <= UPX_ERR_NO_OBJECT;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Program cycle sequencer
  // ------------------------------------------------------------
  upx_seq_e seq_reg; // Current exchange phase
  logic [4:0] slot_reg; // Descriptor being copied

  // Walks all descriptors in, lets the program run one cycle, then out.
  // Limitation: a run phase lasts one clock; slower programs should hold
  // prog_start low until they have consumed the input image.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_reg <= UPX_IDLE;
      slot_reg <= 5'h00;
    end else begin
      case (seq_reg)
        UPX_IDLE: begin
          slot_reg <= 5'h00;
          if (prog_start && prog_inout_decl <= 6'(UPX_MAP_COUNT)) begin
            seq_reg <= UPX_COPY_IN;
          end
        end
        UPX_COPY_IN: begin
          if (slot_reg == 5'(UPX_MAP_N - 1)) begin
            slot_reg <= 5'h00;
            seq_reg <= UPX_RUN;
          end else begin
            slot_reg <= slot_reg + 5'h01;
          end
        end
        UPX_RUN: begin
          seq_reg <= UPX_COPY_OUT;
        end
        UPX_COPY_OUT: begin
          if (slot_reg == 5'(UPX_MAP_N - 1)) begin
            slot_reg <= 5'h00;
            seq_reg <= UPX_IDLE;
          end else begin
            slot_reg <= slot_reg + 5'h01;
          end
        end
        default: begin
          seq_reg <= UPX_IDLE;
        end
      endcase
    end
  end

  // Mapping error sticks until the next start with a legal declaration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_map_error <= UPX_ERR_NONE;
    end else if (seq_reg == UPX_IDLE && prog_start) begin
      prog_map_error <= (prog_inout_decl > 6'(UPX_MAP_COUNT)) ?
                        UPX_ERR_INOUT_OVERFLOW : UPX_ERR_NONE;
    end
  end

  // Completion pulse one clock after the last copy-out slot
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_cycle_done <= 1'b0;
    end else begin
      prog_cycle_done <= (seq_reg == UPX_COPY_OUT) && (slot_reg == 5'(UPX_MAP_N - 1));
    end
  end

  // Copy strobes name each descriptor to the mover outside this bank
  assign prog_running = seq_reg == UPX_RUN;
  assign xfer_slot = slot_reg;
  assign xfer_desc = desc_mem[slot_reg[3:0]];
  assign xfer_in_valid = seq_reg == UPX_COPY_IN;
  assign xfer_out_valid = seq_reg == UPX_COPY_OUT;
endmodule : upx_exchange
`default_nettype wire

// File: core/upx_pkg.sv
// Package: object indices, subindex limits, error codes and reset values of the exchange bank
`default_nettype none
package upx_pkg;
  // ------------------------------------------------------------
  // Object indices
  // ------------------------------------------------------------
  localparam logic [15:0] UPX_IDX_OUT_MAP = 16'h2320;   // Output-only selection table
  localparam logic [15:0] UPX_IDX_INOUT_MAP = 16'h2330; // Combined in/out selection table
  localparam logic [15:0] UPX_IDX_INPUT = 16'h2400;     // Input word array
  localparam logic [15:0] UPX_IDX_INIT = 16'h2410;      // Storable init parameter array
  localparam logic [15:0] UPX_IDX_OUTPUT = 16'h2500;    // Output word array
  // ------------------------------------------------------------
  // Entry counts (subindex 0 values)
  // ------------------------------------------------------------
  localparam logic [7:0] UPX_MAP_COUNT = 8'h10;         // Descriptors per selection table
  localparam logic [7:0] UPX_WORD_COUNT = 8'h20;        // Words per data array
  localparam int UPX_MAP_N = 16;                        // Descriptor array depth
  localparam int UPX_WORD_N = 32;                       // Word array depth
  // ------------------------------------------------------------
  // Descriptor field positions
  // ------------------------------------------------------------
  localparam int UPX_DESC_IDX_LSB = 16;                 // Index in bits 31..16
  localparam int UPX_DESC_SUB_LSB = 8;                  // Subindex in bits 15..8
  localparam int UPX_DESC_LEN_LSB = 0;                  // Length in bits 7..0
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] UPX_MAP_RESET = 32'h0000_0000;
  localparam logic [31:0] UPX_INPUT_RESET = 32'h0000_0000;
  localparam logic [31:0] UPX_INIT_RESET = 32'h0000_0000;
  localparam logic [31:0] UPX_OUTPUT_RESET = 32'h0000_0006;
  // ------------------------------------------------------------
  // Abort and mapping error codes
  // ------------------------------------------------------------
  localparam logic [31:0] UPX_ERR_NONE = 32'h0000_0000;
  localparam logic [31:0] UPX_ERR_NO_OBJECT = 32'h0000_1000;
  localparam logic [31:0] UPX_ERR_READ_ONLY = 32'h0000_1001;
  localparam logic [31:0] UPX_ERR_INOUT_OVERFLOW = 32'h0400_0000;
  // ------------------------------------------------------------
  // Program exchange sequencer states (Gray along the cycle)
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    UPX_IDLE = 2'b00,
    UPX_COPY_IN = 2'b01,
    UPX_RUN = 2'b11,
    UPX_COPY_OUT = 2'b10
  } upx_seq_e;
endpackage : upx_pkg
`default_nettype wire

// File: core/upx_word_bank.sv
// Array of 32-bit words with two write ports and two read ports
`default_nettype none
module upx_word_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] reset_value,
  input wire logic a_we,
  input wire logic [4:0] a_addr,
  input wire logic [31:0] a_wdata,
  output logic [31:0] a_rdata,
  input wire logic b_we,
  input wire logic [4:0] b_addr,
  input wire logic [31:0] b_wdata,
  output logic [31:0] b_rdata
);
  import upx_pkg::*;
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [31:0] mem_reg [UPX_WORD_N];  // One entry per word
  logic [31:0] rst_val_reg;           // Preset captured on every clock, during reset as well

  // Reset value is a port, so it is taken clocked, never inside reset
  always_ff @(posedge mclk) begin
    rst_val_reg <= reset_value;
  end

  // Word store: port a (fieldbus) wins over port b on the same word,
  // since the master's write is the later, external event
  genvar gi;
  generate
    for (gi = 0; gi < UPX_WORD_N; gi++) begin : g_word
      logic init_done_reg; // Word loaded with its preset
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          init_done_reg <= 1'b0;
        end else begin
          init_done_reg <= 1'b1;
        end
      end
      always_ff @(posedge mclk) begin
        if (!init_done_reg) begin
          mem_reg[gi] <= rst_val_reg;
        end else if (a_we && a_addr == 5'(gi)) begin
          mem_reg[gi] <= a_wdata;
        end else if (b_we && b_addr == 5'(gi)) begin
          mem_reg[gi] <= b_wdata;
        end
      end
    end
  endgenerate

  // Reads return the stored word
  assign a_rdata = mem_reg[a_addr];
  assign b_rdata = mem_reg[b_addr];
endmodule : upx_word_bank
`default_nettype wire

// File: verification/upx_exchange_assertions.sv
// Checker: port-level assertions for the exchange bank
`default_nettype none
module upx_exchange_assertions
  import upx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic od_req,
  input wire logic od_write,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic od_done,
  input wire logic [31:0] od_rdata,
  input wire logic [31:0] od_abort,
  input wire logic prog_start,
  input wire logic [5:0] prog_inout_decl,
  input wire logic prog_running,
  input wire logic prog_cycle_done,
  input wire logic [31:0] prog_map_error,
  input wire logic [31:0] xfer_desc,
  input wire logic xfer_in_valid,
  input wire logic xfer_out_valid
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic known; // Index decodes to one of the five objects
  logic idle; // Sequencer shows no activity
  assign known = od_index inside {UPX_IDX_OUT_MAP, UPX_IDX_INOUT_MAP, UPX_IDX_INPUT,
                                  UPX_IDX_INIT, UPX_IDX_OUTPUT};
  assign idle = !xfer_in_valid && !xfer_out_valid && !prog_running;
  // ------------------------------------------------------------
  // Object access
  // ------------------------------------------------------------
  AST_DONE_AFTER_REQ: assert property (od_req |=> od_done)
    else $error("done missing after request");
  AST_NO_STRAY_DONE: assert property (!od_req |=> !od_done)
    else $error("done without request");
  AST_RO_REFUSED: assert property (od_req && od_write && known && od_subindex <= 8'h10 &&
    (od_subindex == 8'h00 || od_index == UPX_IDX_INOUT_MAP) |=> od_abort == UPX_ERR_READ_ONLY)
    else $error("read-only write not refused");
  AST_NO_OBJECT: assert property (od_req && !known |=> od_abort == UPX_ERR_NO_OBJECT)
    else $error("unknown object not refused");
  AST_MAP_COUNT: assert property (od_req && !od_write && od_index == UPX_IDX_INOUT_MAP &&
    od_subindex == 8'h00 |=> od_rdata == 32'h0000_0010 && od_abort == UPX_ERR_NONE)
    else $error("table count wrong");
  AST_INPUT_WRITE: assert property (od_req && od_write && od_index == UPX_IDX_INPUT &&
    od_subindex inside {[8'h01:8'h20]} |=> od_abort == UPX_ERR_NONE)
    else $error("input write refused");
  // ------------------------------------------------------------
  // Program exchange cycle
  // ------------------------------------------------------------
  AST_DESC_ZERO: assert property (xfer_in_valid || xfer_out_valid |->
    xfer_desc == UPX_MAP_RESET) else $error("descriptor not zero");
  AST_SEQUENCE: assert property (prog_start && idle && prog_inout_decl <= 6'd16 |=>
    xfer_in_valid ##15 xfer_in_valid ##1 prog_running ##1 xfer_out_valid ##15 xfer_out_valid
    ##1 prog_cycle_done) else $error("exchange sequence wrong");
  AST_OVERFLOW: assert property (prog_start && idle && prog_inout_decl > 6'd16 |=>
    prog_map_error == UPX_ERR_INOUT_OVERFLOW && !xfer_in_valid) else $error("overflow missed");
endmodule : upx_exchange_assertions
bind upx_exchange upx_exchange_assertions u_chk (.mclk(mclk), .rst(rst), .od_req(od_req),
  .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex), .od_done(od_done),
  .od_rdata(od_rdata), .od_abort(od_abort), .prog_start(prog_start),
  .prog_inout_decl(prog_inout_decl), .prog_running(prog_running),
  .prog_cycle_done(prog_cycle_done), .prog_map_error(prog_map_error),
  .xfer_desc(xfer_desc), .xfer_in_valid(xfer_in_valid), .xfer_out_valid(xfer_out_valid));
`default_nettype wire

// File: verification/upx_master_model.sv
// Fieldbus master model: issues object dictionary requests
`default_nettype none
module upx_master_model (
  input wire logic mclk,
  output logic od_req,
  output logic od_write,
  output logic [15:0] od_index,
  output logic [7:0] od_subindex,
  output logic [31:0] od_wdata,
  input wire logic od_done,
  input wire logic [31:0] od_rdata,
  input wire logic [31:0] od_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus until the first request
  initial begin
    od_req = 1'b0;
    od_write = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
    od_wdata = 32'h0000_0000;
  end
  // One request pulse, then a bounded wait for the answer
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, output logic [31:0] rd, output logic [31:0] ab, output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    ab = 32'h0;
    @(posedge mclk);
    od_req <= 1'b1;
    od_write <= wr;
    od_index <= idx;
    od_subindex <= sub;
    od_wdata <= wd;
    @(posedge mclk);
    // Released lines carry the inverse so stale values cannot pass for live ones
    od_req <= 1'b0;
    od_write <= ~wr;
    od_index <= ~idx;
    od_subindex <= ~sub;
    od_wdata <= ~wd;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge mclk);
      if (od_done === 1'b1) begin
        ok = 1'b1;
        rd = od_rdata;
        ab = od_abort;
      end
    end
  endtask : access
endmodule : upx_master_model
`default_nettype wire

// File: verification/upx_exchange_test.sv
// Testbench: random and corner accesses to the exchange bank
`default_nettype none
module upx_exchange_test;
  timeunit 1ns;
  timeprecision 1ps;
  import upx_pkg::*;
  logic mclk, rst, od_req, od_write, od_done, prog_start, prog_running, prog_cycle_done;
  logic prog_we, xfer_in_valid, xfer_out_valid, nv_we;
  logic [15:0] od_index;
  logic [7:0] od_subindex;
  logic [5:0] prog_inout_decl;
  logic [4:0] prog_addr, xfer_slot, nv_addr;
  logic [31:0] od_wdata, od_rdata, od_abort, prog_map_error, prog_wdata, prog_input_rdata;
  logic [31:0] prog_init_rdata, prog_output_rdata, xfer_desc, nv_wdata, nv_rdata;
  logic [31:0] mirror [0:4][1:32]; // Expected contents of every object word
  int bad_count, total_checks, ins, outs, runs, done_at;
  integer seed = 40;
  upx_master_model u_master (.mclk(mclk), .od_req(od_req), .od_write(od_write),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
    .od_done(od_done), .od_rdata(od_rdata), .od_abort(od_abort));
  upx_exchange u_dut (.mclk(mclk), .rst(rst), .od_req(od_req), .od_write(od_write),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_done(od_done),
    .od_rdata(od_rdata), .od_abort(od_abort), .prog_start(prog_start),
    .prog_inout_decl(prog_inout_decl), .prog_running(prog_running),
    .prog_cycle_done(prog_cycle_done), .prog_map_error(prog_map_error), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_input_rdata(prog_input_rdata),
    .prog_init_rdata(prog_init_rdata), .prog_output_rdata(prog_output_rdata),
    .xfer_slot(xfer_slot), .xfer_desc(xfer_desc), .xfer_in_valid(xfer_in_valid),
    .xfer_out_valid(xfer_out_valid), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_rdata(nv_rdata));
  // ------------------------------------------------------------
  // Clock, expectations and checks
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [15:0] f_idx(int k);
    logic [15:0] t [0:4] = '{UPX_IDX_OUT_MAP, UPX_IDX_INOUT_MAP, UPX_IDX_INPUT, UPX_IDX_INIT,
                             UPX_IDX_OUTPUT};
    return t[k];
  endfunction : f_idx
  function automatic int f_n(int k);
    return (k < 2) ? 16 : 32;
  endfunction : f_n
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // Access through the master model; a lost answer ends the run
  task automatic odx(input logic wr, input int k, input int s, input logic [31:0] wd,
    input logic [31:0] erd, input logic [31:0] eab);
    logic [31:0] rd, ab;
    logic ok;
    u_master.access(wr, f_idx(k), s[7:0], wd, rd, ab, ok);
    if (!ok) begin
      bad_count++;
      $display("BAD %0t no answer", $time);
      complete_run();
    end
    check(rd, erd, "data");
    check(ab, eab, "abort");
  endtask : odx
  // Reset, then mirror takes the presets
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++)
      for (int s = 1; s <= 32; s++) mirror[k][s] = (k == 4) ? UPX_OUTPUT_RESET : 32'h0;
    repeat (2) @(posedge mclk);
  endtask : do_reset
  // Count, refused count write, every word, first subindex past the end
  task automatic sweep();
    for (int k = 0; k < 5; k++) begin
      odx(1'b0, k, 0, 32'h0, f_n(k), UPX_ERR_NONE);
      odx(1'b1, k, 0, 32'h5a, 32'h0, UPX_ERR_READ_ONLY);
      for (int s = 1; s <= f_n(k); s++) odx(1'b0, k, s, 32'h0, mirror[k][s], 32'h0);
      odx(1'b0, k, f_n(k) + 1, 32'h0, 32'h0, UPX_ERR_NO_OBJECT);
    end
  endtask : sweep
  // Start a program cycle and watch it for a bounded time
  task automatic run_prog(input logic [5:0] decl);
    prog_inout_decl <= decl;
    prog_start <= 1'b1;
    @(posedge mclk);
    prog_start <= 1'b0;
    ins = 0;
    outs = 0;
    runs = 0;
    done_at = 0;
    for (int j = 1; j <= 40; j++) begin
      @(posedge mclk);
      if (xfer_in_valid === 1'b1) begin
        check(xfer_slot, ins, "copy-in slot");
        check(xfer_desc, UPX_MAP_RESET, "copy-in descriptor");
        ins++;
      end
      if (xfer_out_valid === 1'b1) begin
        check(xfer_slot, outs, "copy-out slot");
        outs++;
      end
      if (prog_running === 1'b1) runs++;
      if (prog_cycle_done === 1'b1 && done_at == 0) done_at = j;
    end
    check(ins, (decl > 16) ? 0 : 16, "copy-in slots");
    check(outs, (decl > 16) ? 0 : 16, "copy-out slots");
    check(runs, (decl > 16) ? 0 : 1, "run phase");
    check(done_at, (decl > 16) ? 0 : 34, "cycle end");
    check(prog_map_error, (decl > 16) ? UPX_ERR_INOUT_OVERFLOW : UPX_ERR_NONE, "map");
  endtask : run_prog
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int k, s;
    logic [31:0] d;
    logic [31:0] e;
    logic ok;
    {rst, prog_start, prog_we, nv_we} = 4'h8;
    {prog_inout_decl, prog_addr, nv_addr, prog_wdata, nv_wdata} = '0;
    bad_count = 0;
    total_checks = 0;
    do_reset();
    sweep();
    odx(1'b1, 1, 3, 32'hffff_ffff, 32'h0, UPX_ERR_READ_ONLY);
    u_master.access(1'b0, 16'h2600, 8'h01, 32'h0, e, d, ok); // Object outside this bank
    check({31'h0, ok}, 32'h1, "foreign answer");
    check(d, UPX_ERR_NO_OBJECT, "foreign object");
    check(e, 32'h0, "foreign data");
    // Random round trips into the three arrays, last word of a randomly chosen array as corner
    for (int i = 0; i < 40; i++) begin
      k = 2 + ($unsigned($random(seed)) % 3);
      s = (i == 0) ? 32 : 1 + ($unsigned($random(seed)) % 32);
      d = $random(seed);
      odx(1'b1, k, s, d, 32'h0, UPX_ERR_NONE);
      mirror[k][s] = d;
      odx(1'b0, k, s, 32'h0, d, UPX_ERR_NONE);
    end
    // Program sees the fieldbus input, writes an output, store restores init
    prog_addr <= 5'd31;
    @(posedge mclk);
    check(prog_input_rdata, mirror[2][32], "program input");
    // Program init read follows the released (inverted) master subindex
    check(prog_init_rdata, mirror[3][((254 - s) % 32) + 1], "program init");
    d = $random(seed);
    {prog_we, prog_wdata, nv_we, nv_addr, nv_wdata} <= {1'b1, d, 1'b1, 5'd4, ~d};
    @(posedge mclk);
    {prog_we, nv_we} <= 2'b00;
    mirror[4][32] = d;
    mirror[3][5] = ~d;
    @(posedge mclk);
    check(prog_output_rdata, d, "program output");
    check(nv_rdata, ~d, "store readback");
    sweep();
    run_prog(6'd17);
    run_prog(6'd16);
    do_reset();
    sweep();
    complete_run();
  end
endmodule : upx_exchange_test
`default_nettype wire
